// ---- rtl/mra_region_attr_check.sv ----
// Summary of operation
// - Bit 28 set forbids instruction fetches
// - Access permission field at bits 26:24
// - Type extension 21:19, C 17, B 16, S 18
// - Bits 15:8 disable subregions when set
// - Size code 5:1, length two to code+1
// - Sizes 32 bytes to 4 Gbytes, min code 4
// - Bit 0 enables region for checking
// - Attributes upper half, size and enables lower
// - Disallowed access raises a permission fault
// - Extension 000 memory type decode
// - Extension 001 memory type decode
// - Extension 010 device or reserved
// - Extension 1xx: outer and inner cache policies
// - Two-bit cache policy code decode
// - Permission codes 000 to 011
// - Permission codes 100 to 111
// - Violation raises exception, records cause
// - Attribute access goes to selected region
module mra_region_attr_check #(
    parameter int NUM_REGIONS = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Access to be checked
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic acc_write,
    input wire logic acc_fetch,
    input wire logic acc_priv,
    // Check result, one cycle later
    output logic chk_valid,
    output logic chk_fault,
    output mra_pkg::mra_mem_t chk_mem_type,
    output logic chk_shareable,
    output mra_pkg::mra_policy_t chk_inner,
    output mra_pkg::mra_policy_t chk_outer,
    output logic chk_impl_def,
    output logic protection_fault_exception
);
    localparam int SW = $clog2(NUM_REGIONS);
    localparam int NOEX = mra_pkg::NOEXEC_BIT;

    if (NUM_REGIONS != 8 && NUM_REGIONS != 16) begin : g_bad_regions
        $error("NUM_REGIONS must be 8 or 16");
    end

    // Register file and bus state
    logic [SW-1:0] region_select, next_region_select;
    logic [31:0] region_attr_size [NUM_REGIONS];
    logic [31:0] next_attr [NUM_REGIONS];
    logic [26:0] region_base [NUM_REGIONS];
    logic [26:0] next_base [NUM_REGIONS];
    logic [7:0] memfault_status, next_memfault_status;
    logic [31:0] fault_addr, next_fault_addr;
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_go, rd_go, wr_ok;
    // Check path
    logic [NUM_REGIONS-1:0] hit, perm_ok;
    logic win_hit;
    logic [SW-1:0] win_idx;
    logic [31:0] win_attr;
    logic [2:0] ext;
    logic [1:0] cb;
    logic d_rsv, next_fault, next_exc;
    logic next_chk_valid, next_shr, next_impl;
    mra_pkg::mra_mem_t next_type;
    mra_pkg::mra_policy_t next_in, next_out;

    // One checker per region
    for (genvar i = 0; i < NUM_REGIONS; i++) begin : g_region
        mra_region_check u_chk (
            .attr(region_attr_size[i]),
            .base(region_base[i]),
            .addr(acc_addr),
            .is_write(acc_write),
            .is_priv(acc_priv),
            .hit(hit[i]),
            .perm_ok(perm_ok[i])
        );
    end

    // Highest numbered matching region wins on overlap
    always_comb begin
        win_hit = 1'b0;
        win_idx = '0;
        for (int i = 0; i < NUM_REGIONS; i++) begin
            if (hit[i]) begin
                win_hit = 1'b1;
                win_idx = SW'(i);
            end
        end
        win_attr = region_attr_size[win_idx];
    end

    // Memory type decode of the winning region
    always_comb begin
        ext = win_attr[mra_pkg::EXT_HI:mra_pkg::EXT_LO];
        cb = {win_attr[mra_pkg::C_BIT], win_attr[mra_pkg::B_BIT]};
        next_type = mra_pkg::MRA_NORMAL;
        next_shr = win_attr[mra_pkg::S_BIT];
        next_in = mra_pkg::mra_policy_t'(cb);
        next_out = mra_pkg::mra_policy_t'(cb);
        next_impl = 1'b0;
        d_rsv = 1'b0;
        if (ext[2]) begin
            next_out = mra_pkg::mra_policy_t'(ext[1:0]);
        end else begin
            unique case (ext[1:0])
                2'b00: begin
                    // Ordered types of extension 000 are always shareable
                    if (!cb[1]) begin
                        next_type = cb[0] ? mra_pkg::MRA_DEVICE : mra_pkg::MRA_STRONG;
                        next_shr = 1'b1;
                        next_in = mra_pkg::MRA_NC;
                        next_out = mra_pkg::MRA_NC;
                    end
                end
                2'b01: begin
                    unique case (cb)
                        2'b00: next_in = mra_pkg::MRA_NC;
                        2'b01: d_rsv = 1'b1;
                        2'b10: next_impl = 1'b1;
                        2'b11: next_in = mra_pkg::MRA_WBWA;
                    endcase
                    next_out = next_in;
                end
                2'b10: begin
                    next_type = mra_pkg::MRA_DEVICE;
                    next_shr = 1'b0;
                    next_in = mra_pkg::MRA_NC;
                    next_out = mra_pkg::MRA_NC;
                    d_rsv = (cb != 2'b00);
                end
                default: d_rsv = 1'b1;
            endcase
        end
        if (d_rsv) begin
            next_type = mra_pkg::MRA_RSVD;
        end
        // No match, denied permission, fetch from never-execute or bad type
        next_fault = !win_hit || !perm_ok[win_idx] || d_rsv
            || (acc_fetch && win_attr[NOEX]);
        next_chk_valid = acc_valid;
        next_exc = acc_valid && next_fault;
    end

    // Check result registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chk_valid <= 1'b0;
            chk_fault <= 1'b0;
            chk_mem_type <= mra_pkg::MRA_STRONG;
            chk_shareable <= 1'b0;
            chk_inner <= mra_pkg::MRA_NC;
            chk_outer <= mra_pkg::MRA_NC;
            chk_impl_def <= 1'b0;
            protection_fault_exception <= 1'b0;
        end else begin
            chk_valid <= next_chk_valid;
            chk_fault <= next_fault && acc_valid;
            chk_mem_type <= next_type;
            chk_shareable <= next_shr;
            chk_inner <= next_in;
            chk_outer <= next_out;
            chk_impl_def <= next_impl;
            protection_fault_exception <= next_exc;
        end
    end

    // Bus handshakes; a write needs address and data both held
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    // Registers take aligned whole words only
    assign wr_ok = (w_strb == 4'hf) && (aw_addr == mra_pkg::OFF_SELECT
        || aw_addr == mra_pkg::OFF_BASE || aw_addr == mra_pkg::OFF_ATTR
        || aw_addr == mra_pkg::OFF_STATUS);

    // Next register and bus values
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_region_select = region_select;
        next_attr = region_attr_size;
        next_base = region_base;
        next_memfault_status = memfault_status;
        next_fault_addr = fault_addr;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_ok ? mra_pkg::RESP_OKAY : mra_pkg::RESP_SLVERR;
            if (wr_ok && aw_addr == mra_pkg::OFF_SELECT) begin
                next_region_select = w_data[SW-1:0];
            end
            if (wr_ok && aw_addr == mra_pkg::OFF_ATTR) begin
                next_attr[region_select] = w_data & mra_pkg::ATTR_MASK;
            end
            if (wr_ok && aw_addr == mra_pkg::OFF_BASE) begin
                // A valid-marked write also moves the region selection
                if (w_data[mra_pkg::VALID_BIT]) begin
                    next_region_select = w_data[SW-1:0];
                    next_base[w_data[SW-1:0]] = w_data[31:mra_pkg::BASE_LO];
                end else begin
                    next_base[region_select] = w_data[31:mra_pkg::BASE_LO];
                end
            end
            if (wr_ok && aw_addr == mra_pkg::OFF_STATUS) begin
                next_memfault_status = memfault_status & ~w_data[7:0];
            end
        end
        // Recording after the clear so a fault in the same cycle survives
        if (acc_valid && next_fault) begin
            next_memfault_status[mra_pkg::ST_FETCH] = acc_fetch
                || next_memfault_status[mra_pkg::ST_FETCH];
            next_memfault_status[mra_pkg::ST_DATA] = !acc_fetch
                || next_memfault_status[mra_pkg::ST_DATA];
            next_memfault_status[mra_pkg::ST_ADDR_VALID] = !acc_fetch
                || next_memfault_status[mra_pkg::ST_ADDR_VALID];
            if (!acc_fetch) begin
                next_fault_addr = acc_addr;
            end
        end
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rresp = mra_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                mra_pkg::OFF_SELECT: next_rdata = 32'(region_select);
                mra_pkg::OFF_BASE: next_rdata = {region_base[region_select], 1'b0,
                    4'(region_select)};
                mra_pkg::OFF_ATTR: next_rdata = region_attr_size[region_select];
                mra_pkg::OFF_STATUS: next_rdata = {24'h00_0000, memfault_status};
                mra_pkg::OFF_FADDR: next_rdata = fault_addr;
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = mra_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // Register and bus flip-flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mra_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= mra_pkg::RESP_OKAY;
            region_select <= '0;
            memfault_status <= mra_pkg::STATUS_RST;
            fault_addr <= mra_pkg::FADDR_RST;
            for (int i = 0; i < NUM_REGIONS; i++) begin
                region_attr_size[i] <= mra_pkg::ATTR_RST;
                region_base[i] <= mra_pkg::BASE_RST;
            end
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            region_select <= next_region_select;
            memfault_status <= next_memfault_status;
            fault_addr <= next_fault_addr;
            region_attr_size <= next_attr;
            region_base <= next_base;
        end
    end

    property p_nx_fetch;
        @(posedge aclk) disable iff (!aresetn)
        acc_valid && acc_fetch && win_hit && win_attr[NOEX] |=> chk_valid && chk_fault;
    endproperty
    a_nx_fetch: assert property (p_nx_fetch) else $error("fetch from never-execute passed");

    property p_full_access;
        @(posedge aclk) disable iff (!aresetn)
        acc_valid && win_hit && win_attr[26:24] == 3'b011 && !d_rsv && !acc_fetch
            |=> !chk_fault;
    endproperty
    a_full_access: assert property (p_full_access) else $error("full access faulted");

    property p_ro_write;
        @(posedge aclk) disable iff (!aresetn)
        acc_valid && acc_write && win_hit && win_attr[26:25] == 2'b11 |=> chk_fault;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write passed");

    property p_no_region;
        @(posedge aclk) disable iff (!aresetn)
        acc_valid && hit == '0 |=> chk_fault && memfault_status != 8'h00;
    endproperty
    a_no_region: assert property (p_no_region) else $error("unmatched access passed");

    property p_exception;
        @(posedge aclk) disable iff (!aresetn)
        protection_fault_exception == (chk_valid && chk_fault);
    endproperty
    a_exception: assert property (p_exception) else $error("exception mismatch");

    property p_rsvd_zero;
        @(posedge aclk) disable iff (!aresetn)
        (region_attr_size[region_select] & ~mra_pkg::ATTR_MASK) == 32'h0000_0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved attribute bit set");

    property p_attr_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_go && wr_ok && aw_addr == mra_pkg::OFF_ATTR
            |=> region_attr_size[$past(region_select)] == ($past(w_data) & mra_pkg::ATTR_MASK);
    endproperty
    a_attr_write: assert property (p_attr_write) else $error("attribute write lost");

    property p_strong;
        @(posedge aclk) disable iff (!aresetn)
        acc_valid && ext == 3'b000 && cb == 2'b00
            |=> chk_mem_type == mra_pkg::MRA_STRONG && chk_shareable;
    endproperty
    a_strong: assert property (p_strong) else $error("strongly-ordered decode wrong");

    property p_cached;
        @(posedge aclk) disable iff (!aresetn)
        acc_valid && ext[2]
            |=> chk_mem_type == mra_pkg::MRA_NORMAL && chk_inner == $past(cb)
                && chk_outer == $past(ext[1:0]);
    endproperty
    a_cached: assert property (p_cached) else $error("cached policy decode wrong");
endmodule : mra_region_attr_check

// ---- shared/mra_pkg.sv ----
package mra_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFF_SELECT = 8'h00;
    localparam logic [7:0] OFF_BASE = 8'h04;
    localparam logic [7:0] OFF_ATTR = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_FADDR = 8'h10;
    // Attribute word field positions
    localparam int NOEXEC_BIT = 28;
    localparam int PERM_HI = 26;
    localparam int PERM_LO = 24;
    localparam int EXT_HI = 21;
    localparam int EXT_LO = 19;
    localparam int S_BIT = 18;
    localparam int C_BIT = 17;
    localparam int B_BIT = 16;
    localparam int SDIS_HI = 15;
    localparam int SDIS_LO = 8;
    localparam int SIZE_HI = 5;
    localparam int SIZE_LO = 1;
    localparam int EN_BIT = 0;
    // Writable bits of the attribute word; the rest read as zero
    localparam logic [31:0] ATTR_MASK = 32'h173f_ff3f;
    localparam logic [4:0] SIZE_MIN = 5'h04;
    localparam logic [4:0] SIZE_NOSUB_MAX = 5'h06;
    // Base register fields
    localparam int BASE_LO = 5;
    localparam int VALID_BIT = 4;
    // Fault status bits
    localparam int ST_FETCH = 0;
    localparam int ST_DATA = 1;
    localparam int ST_ADDR_VALID = 7;
    // Reset values
    localparam logic [31:0] ATTR_RST = 32'h0000_0000;
    localparam logic [26:0] BASE_RST = 27'h000_0000;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [31:0] FADDR_RST = 32'h0000_0000;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MRA_STRONG = 2'b00,
        MRA_DEVICE = 2'b01,
        MRA_NORMAL = 2'b10,
        MRA_RSVD = 2'b11
    } mra_mem_t;

    // Cache policy codes, shared by inner and outer
    typedef enum logic [1:0] {
        MRA_NC = 2'b00,
        MRA_WBWA = 2'b01,
        MRA_WT = 2'b10,
        MRA_WB = 2'b11
    } mra_policy_t;
endpackage : mra_pkg

// ---- rtl/mra_region_check.sv ----
// Match and permission check of one region against one access
module mra_region_check (
    // Region programming
    input wire logic [31:0] attr,
    input wire logic [26:0] base,
    // Access
    input wire logic [31:0] addr,
    input wire logic is_write,
    input wire logic is_priv,
    // Result
    output logic hit,
    output logic perm_ok
);
    logic [4:0] sz;
    logic [32:0] low;
    logic [2:0] sub;
    logic [7:0] sdb;
    logic sub_off;
    logic [2:0] pm;
    logic rd_ok;
    logic wr_ok;

    // Region match, subregion gating and permission decode
    always_comb begin
        sz = attr[mra_pkg::SIZE_HI:mra_pkg::SIZE_LO];
        if (sz < mra_pkg::SIZE_MIN) begin
            sz = mra_pkg::SIZE_MIN;
        end
        // Length is 2^(size+1); 33 bits so code 31 covers the whole map
        low = (33'h1 << ({1'b0, sz} + 6'd1)) - 33'h1;
        sub = 3'(addr >> (sz - 5'd2));
        sdb = attr[mra_pkg::SDIS_HI:mra_pkg::SDIS_LO];
        // Small regions have no subregions, so a stray field is ignored
        sub_off = (sz > mra_pkg::SIZE_NOSUB_MAX) && sdb[sub];
        hit = attr[mra_pkg::EN_BIT] && !sub_off
            && (((addr ^ {base, 5'h00}) & ~low[31:0]) == 32'h0000_0000);
        pm = attr[mra_pkg::PERM_HI:mra_pkg::PERM_LO];
        unique case (pm)
            3'b000: {rd_ok, wr_ok} = 2'b00;
            3'b001: {rd_ok, wr_ok} = {is_priv, is_priv};
            3'b010: {rd_ok, wr_ok} = {1'b1, is_priv};
            3'b011: {rd_ok, wr_ok} = 2'b11;
            3'b100: {rd_ok, wr_ok} = 2'b00;
            3'b101: {rd_ok, wr_ok} = {is_priv, 1'b0};
            3'b110: {rd_ok, wr_ok} = 2'b10;
            3'b111: {rd_ok, wr_ok} = 2'b10;
        endcase
        perm_ok = is_write ? wr_ok : rd_ok;
    end
endmodule : mra_region_check

// ---- sim/mra_core_model.sv ----
// Load/store and fetch path of the core, one access request per clock
module mra_core_model (
    // Clock
    input wire logic aclk,
    // Access request
    output logic acc_valid,
    output logic [31:0] acc_addr,
    output logic acc_write,
    output logic acc_fetch,
    output logic acc_priv
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet request lines from time zero
    initial begin
        acc_valid = 1'b0;
        acc_addr = 32'h0000_0000;
        {acc_write, acc_fetch, acc_priv} = 3'h0;
    end
    // One access per edge; called just after a rising edge, so requests may run back to back
    task automatic drive(input logic [31:0] a, input logic [2:0] wfp);
        acc_valid <= 1'b1;
        acc_addr <= a;
        {acc_write, acc_fetch, acc_priv} <= wfp;
        @(posedge aclk);
    endtask : drive
    // Released lines flip, so a stale address can never pass for a live one
    task automatic idle();
        acc_valid <= 1'b0;
        acc_addr <= ~acc_addr;
        {acc_write, acc_fetch, acc_priv} <= ~{acc_write, acc_fetch, acc_priv};
        @(posedge aclk);
    endtask : idle
endmodule : mra_core_model

// ---- sim/tb_mra_region_attr_check.sv ----
module tb_mra_region_attr_check;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK = mra_pkg::RESP_OKAY;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, acc_addr, a;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic acc_valid, acc_write, acc_fetch, acc_priv;
    logic chk_valid, chk_fault, chk_shareable, fault_exc, impl;
    mra_pkg::mra_mem_t chk_mem_type;
    mra_pkg::mra_policy_t chk_inner, chk_outer;
    int bad_count, checks_done;
    logic [16:0] aq[$];
    logic [33:0] rq[$];
    logic [1:0] bq[$];

    mra_region_attr_check #(.NUM_REGIONS(8)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
        .acc_fetch(acc_fetch), .acc_priv(acc_priv), .chk_valid(chk_valid),
        .chk_fault(chk_fault), .chk_mem_type(chk_mem_type), .chk_shareable(chk_shareable),
        .chk_inner(chk_inner), .chk_outer(chk_outer), .chk_impl_def(impl),
        .protection_fault_exception(fault_exc));
    mra_core_model core_u (.aclk(aclk), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_write(acc_write), .acc_fetch(acc_fetch), .acc_priv(acc_priv));

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // Results are matched against the oldest note as they appear
    always @(posedge aclk) begin
        logic [16:0] e;
        if (chk_valid === 1'b1) begin
            e = aq.pop_front();
            chk("attr", {chk_fault, chk_mem_type, chk_shareable, chk_inner, chk_outer} & e[15:8],
                e[7:0] & e[15:8]);
            chk("exception", fault_exc, e[7]);
            chk("impl", impl, e[16]);
        end
        if (bvalid === 1'b1 && bready === 1'b1) chk("bresp", bresp, bq.pop_front());
        if (rvalid === 1'b1 && rready === 1'b1) chk("read", {rresp, rdata}, rq.pop_front());
    end

    // One register write or read; every wait is bounded and a hang ends the run
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
        input logic [1:0] r);
        int n;
        n = 0;
        if (w) bq.push_back(r);
        else rq.push_back({r, d});
        awaddr <= ad;
        araddr <= ad;
        wdata <= d;
        {awvalid, wvalid, bready} <= {3{w}};
        {arvalid, rready} <= {2{!w}};
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (((w ? bvalid : rvalid) !== 1'b1) && n < 100);
        {bready, rready} <= 2'b00;
        if (n >= 100) begin
            bad_count++;
            give_verdict();
        end
        @(posedge aclk);
    endtask : bus

    task automatic prog(input logic [31:0] rg, input logic [31:0] base, input logic [31:0] at);
        bus(1'b1, mra_pkg::OFF_SELECT, rg, OK);
        bus(1'b1, mra_pkg::OFF_BASE, base, OK);
        bus(1'b1, mra_pkg::OFF_ATTR, at, OK);
    endtask : prog

    task automatic acc(input logic [31:0] ad, input logic [2:0] wfp, input logic [16:0] e);
        aq.push_back(e);
        core_u.drive(ad, wfp);
    endtask : acc

    // Attribute word; tcbs packs type extension, cacheable, bufferable, shareable
    function automatic logic [31:0] mk(input logic nx, input logic [2:0] perm,
        input logic [5:0] tcbs, input logic [7:0] sub_off, input logic [4:0] sz, input logic en);
        return {3'h0, nx, 1'b0, perm, 2'h0, tcbs[5:3], tcbs[0], tcbs[2:1], sub_off, 2'h0, sz, en};
    endfunction : mk

    // Fault for k: 0..3 is {priv, write}, 4 a privileged fetch
    function automatic logic fx(input logic [2:0] perm, input int k, input logic nx);
        logic w, p, ok;
        w = k == 1 || k == 3;
        p = k >= 2;
        case (perm)
            3'h0, 3'h4: ok = 1'b0;
            3'h1: ok = p;
            3'h2: ok = p || !w;
            3'h3: ok = 1'b1;
            3'h5: ok = p && !w;
            default: ok = !w;
        endcase
        return !ok || (k == 4 && nx);
    endfunction : fx

    // Mask and value of {fault, type, shareable, inner, outer}
    function automatic logic [15:0] mexp(input logic [5:0] k);
        logic [2:0] t;
        logic [1:0] cb;
        t = k[5:3];
        cb = k[2:1];
        if (t[2]) return {8'hff, 3'b010, k[0], cb, t[1:0]}; // Outer from low type bits
        case ({t[1:0], cb})
            4'h0: return 16'hf0_10;
            4'h1: return 16'hf0_30;
            4'h2: return {8'hff, 3'b010, k[0], 4'ha};
            4'h3: return {8'hff, 3'b010, k[0], 4'hf};
            4'h4: return {8'hff, 3'b010, k[0], 4'h0};
            4'h6: return 16'h80_00; // Implementation defined: only the fault is known
            4'h7: return {8'hff, 3'b010, k[0], 4'h5};
            4'h8: return 16'hf0_20;
            default: return 16'he0_e0; // Reserved encodings fault
        endcase
    endfunction : mexp

    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        a = $urandom(84131);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bus(1'b0, mra_pkg::OFF_ATTR, mra_pkg::ATTR_RST, OK);
        bus(1'b1, mra_pkg::OFF_ATTR, 32'hffff_ffff, OK);
        wstrb <= 4'h3;
        bus(1'b1, mra_pkg::OFF_ATTR, 32'h0, mra_pkg::RESP_SLVERR);
        wstrb <= 4'hf;
        bus(1'b0, mra_pkg::OFF_ATTR, mra_pkg::ATTR_MASK, OK);
        bus(1'b1, 8'h14, 32'h1, mra_pkg::RESP_SLVERR);
        bus(1'b0, 8'h14, 32'h0, mra_pkg::RESP_SLVERR);
        $display("test registers done");
        for (int perm = 0; perm < 8; perm++) begin
            prog(0, 0, mk(perm[0], perm[2:0], 6'b000110, 8'h00, 5'h1f, 1'b1));
            for (int k = 0; k < 5; k++) begin
                a = $urandom;
                acc(a, k == 4 ? 3'b011 : {k[0], 1'b0, k[1]},
                    {9'h0e0, fx(perm[2:0], k, perm[0]), 2'b10, 5'h0});
            end
            core_u.idle();
        end
        $display("test permissions done");
        for (int t = 0; t < 64; t++) begin
            bus(1'b1, mra_pkg::OFF_ATTR, mk(1'b0, 3'h3, t[5:0], 8'h00, 5'h1f, 1'b1), OK);
            acc($urandom, 3'b001, {t[5:1] == 5'b00110, mexp(t[5:0])});
            core_u.idle();
        end
        $display("test memory types done");
        prog(0, 0, mk(1'b0, 3'h0, 6'b000110, 8'h00, 5'h0c, 1'b1));
        prog(1, 32'h1000, mk(1'b0, 3'h3, 6'b000110, 8'h02, 5'h07, 1'b1));
        prog(2, 32'h2000, mk(1'b0, 3'h3, 6'b000110, 8'h00, 5'h04, 1'b1));
        acc(32'h0000_1000, 3'b000, 17'h08000);
        acc(32'h0000_1020, 3'b000, 17'h08080);
        acc(32'h0000_10e0, 3'b000, 17'h08000);
        acc(32'h0000_1100, 3'b000, 17'h08080);
        acc(32'h0000_201f, 3'b000, 17'h08000);
        acc(32'h0000_2020, 3'b000, 17'h08080);
        core_u.idle();
        bus(1'b1, mra_pkg::OFF_BASE, 32'h0000_1011, OK);
        bus(1'b0, mra_pkg::OFF_SELECT, 32'h1, OK);
        bus(1'b0, mra_pkg::OFF_ATTR, mk(1'b0, 3'h3, 6'b000110, 8'h02, 5'h07, 1'b1), OK);
        bus(1'b1, mra_pkg::OFF_ATTR, mk(1'b0, 3'h3, 6'b000110, 8'h02, 5'h07, 1'b0), OK);
        acc(32'h0000_1000, 3'b000, 17'h08080);
        core_u.idle();
        core_u.idle();
        $display("test regions done");
        bus(1'b0, mra_pkg::OFF_STATUS, 32'h0000_0083, OK);
        bus(1'b0, mra_pkg::OFF_FADDR, 32'h0000_1000, OK);
        bus(1'b1, mra_pkg::OFF_STATUS, 32'h0000_00ff, OK);
        bus(1'b0, mra_pkg::OFF_STATUS, 32'h0, OK);
        $display("test status done");
        chk("pending", aq.size(), 0);
        give_verdict();
    end
endmodule : tb_mra_region_attr_check
